//--- logic/chf_config.sv
// Charger switch, watchdog and thermistor configuration register bank.
// Assumes an AXI4-Lite master on core_clk and asynchronous analog flags.
//
// What this block does
// - Regulation code passes up to 55; higher codes select the code 55 level.
// - Bits 7:6 select minimum system voltage; code 3 is reserved.
// - Writing 01 to the clear field restarts an enabled watchdog only.
// - Period bit 6 picks 80 s when clear, 32 s when set.
// - Watchdog switch-control bit 2 is stored and read back, drives nothing.
// - Inhibit clear: overcurrent lasting 16 ms opens the isolation switch.
// - Inhibit set: overcurrent leaves the isolation switch closed.
// - Bits 5:4 pick overcurrent threshold; code 0 disables detection.
// - Bit 7 enables overcurrent protection while no input supply is present.
// - Mode 0 ignores thermistor yet still raises cool and warm interrupts.
// - Mode 1 stops charging above hot or below cold threshold.
// - Mode 2 cuts current and voltage outside the warm and cool thresholds.
// - Mode 3 cuts only current outside the warm and cool thresholds.
// - Die above set point folds back current and sets regulation flag.
// - Bit 4 selects the cold threshold: 0 C clear, -10 C set.
// - Bit 5 selects the hot threshold: 60 C clear, 55 C set.
`timescale 1ns/1ps
module chf_config
    import chf_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter longint unsigned WD_LONG_CYCLES = WD_LONG_CYC,
    parameter longint unsigned WD_SHORT_CYCLES = WD_SHORT_CYC,
    parameter longint unsigned OC_DEB_CYCLES = OC_DEB_CYC
)
(
    // Clock, reset and freeze
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog comparator flags, asynchronous
    input wire logic batt_overcurrent,
    input wire logic vbus_present,
    input wire logic temp_above_hot,
    input wire logic temp_above_warm,
    input wire logic temp_below_cool,
    input wire logic temp_below_cold,
    input wire logic die_above_set_point,
    // Watchdog enable from core logic
    input wire logic watchdog_enable,
    // Selections to the analog loops
    output logic [5:0] battery_regulation_voltage_code,
    output logic [1:0] minimum_system_voltage_select,
    output logic [1:0] switch_overcurrent_threshold,
    output logic [1:0] junction_temperature_set_point,
    output logic cold_threshold_select,
    output logic hot_threshold_select,
    // Charger control and status
    output logic battery_isolation_switch_open,
    output logic charge_stop,
    output logic charge_current_reduce,
    output logic regulation_voltage_reduce,
    output logic current_foldback,
    output logic thermal_regulation_status_flag,
    output logic watchdog_expired,
    output logic irq
);
    localparam logic [WD_CNT_W-1:0] WD_LONG_LIM =
        WD_CNT_W'(WD_LONG_CYCLES - 64'd1);
    localparam logic [WD_CNT_W-1:0] WD_SHORT_LIM =
        WD_CNT_W'(WD_SHORT_CYCLES - 64'd1);
    localparam logic [OC_CNT_W-1:0] OC_LIM =
        OC_CNT_W'(OC_DEB_CYCLES - 64'd1);

    typedef struct packed {
        logic [7:0] breg;
        logic [7:0] swreg;
        logic [7:0] threg;
        logic [IRQ_W-1:0] irq_st;
        logic [IRQ_W-1:0] irq_en;
        logic aw_held;
        logic w_held;
        logic [5:0] w_idx;
        logic [7:0] w_data;
        logic w_strb0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [7:0] rdata;
        logic [1:0] rresp;
        logic [WD_CNT_W-1:0] wd_cnt;
        logic [OC_CNT_W-1:0] oc_cnt;
        logic sw_open;
        logic prev_cool;
        logic prev_warm;
        logic prev_die;
        logic [5:0] v_code;
        logic [1:0] vsys;
        logic [1:0] oc_thr;
        logic [1:0] set_pt;
        logic cold_sel;
        logic hot_sel;
        logic stop;
        logic cur_red;
        logic volt_red;
        logic fold;
        logic treg;
        logic wd_exp;
        logic irq;
    } chf_state_t;

    // Defaults; bus ready lines come up high
    localparam chf_state_t ST_RST = '{
        breg: RST_BATT_REG,
        swreg: RST_SWITCH_WD,
        threg: RST_THERM,
        awready: 1'b1,
        wready: 1'b1,
        arready: 1'b1,
        v_code: RST_BATT_REG[5:0],
        vsys: RST_BATT_REG[F_VSYS_LSB +: 2],
        oc_thr: RST_SWITCH_WD[F_OCTHR_LSB +: 2],
        set_pt: RST_THERM[F_SETPT_LSB +: 2],
        cold_sel: RST_THERM[F_COLD_BIT],
        hot_sel: RST_THERM[F_HOT_BIT],
        default: '0
    };

    chf_state_t st_q;
    chf_state_t st_d;
    logic [6:0] pins_s;
    logic oc_s;
    logic vbus_s;
    logic hot_s;
    logic warm_s;
    logic cool_s;
    logic cold_s;
    logic die_s;
    logic wd_kick;
    logic oc_active;
    logic [WD_CNT_W-1:0] wd_limit;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;

    // All analog flags cross through two flops
    chf_sync #(.W(7)) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .ce(ce),
        .async_in({die_above_set_point, temp_below_cold, temp_below_cool,
                   temp_above_warm, temp_above_hot, vbus_present,
                   batt_overcurrent}),
        .sync_out(pins_s)
    );

    assign oc_s = pins_s[0];
    assign vbus_s = pins_s[1];
    assign hot_s = pins_s[2];
    assign warm_s = pins_s[3];
    assign cool_s = pins_s[4];
    assign cold_s = pins_s[5];
    assign die_s = pins_s[6];

    // Codes past the table top all pick its highest voltage
    function automatic logic [5:0] sat_code(input logic [5:0] c);
        sat_code = (c > CODE_MAX) ? CODE_MAX : c;
    endfunction

    // Next state: bus slave, watchdog, overcurrent timer, thermistor logic
    always_comb
    begin
        st_d = st_q;
        st_d.wd_exp = 1'b0;
        clr = '0;
        wd_kick = 1'b0;
        // Address and data are taken independently, in either order
        if (s_axi_awvalid && st_q.awready)
        begin
            st_d.aw_held = 1'b1;
            st_d.w_idx = 6'(s_axi_awaddr >> 2);
        end
        if (s_axi_wvalid && st_q.wready)
        begin
            st_d.w_held = 1'b1;
            st_d.w_data = s_axi_wdata[7:0];
            st_d.w_strb0 = s_axi_wstrb[0];
        end
        if (st_q.bvalid && s_axi_bready)
            st_d.bvalid = 1'b0;
        // Commit only once the previous response has been taken
        if (st_q.aw_held && st_q.w_held && !st_q.bvalid)
        begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            case (st_q.w_idx)
                IDX_BATT_REG:
                begin
                    if (st_q.w_strb0)
                        st_d.breg = st_q.w_data;
                end
                IDX_SWITCH_WD:
                begin
                    if (st_q.w_strb0)
                        st_d.swreg = st_q.w_data;
                    wd_kick = st_q.w_strb0 && watchdog_enable &&
                        (st_q.w_data[F_WDCLR_LSB +: 2] == WD_CLEAR_KEY);
                end
                IDX_THERM:
                begin
                    if (st_q.w_strb0)
                        st_d.threg = st_q.w_data;
                end
                IDX_IRQ_ENABLE:
                begin
                    if (st_q.w_strb0)
                        st_d.irq_en = st_q.w_data[IRQ_W-1:0];
                end
                IDX_IRQ_CLEAR:
                begin
                    if (st_q.w_strb0)
                        clr = st_q.w_data[IRQ_W-1:0];
                end
                IDX_IRQ_STATUS: ; // Read-only, write ignored
                default: st_d.bresp = RESP_SLVERR;
            endcase
        end
        st_d.awready = !st_d.aw_held;
        st_d.wready = !st_d.w_held;

        // Read: one beat, answered the cycle after the address is taken
        if (st_q.rvalid && s_axi_rready)
            st_d.rvalid = 1'b0;
        if (s_axi_arvalid && st_q.arready)
        begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            case (6'(s_axi_araddr >> 2))
                IDX_BATT_REG: st_d.rdata = st_q.breg;
                IDX_SWITCH_WD: st_d.rdata = st_q.swreg;
                IDX_THERM: st_d.rdata = st_q.threg;
                IDX_IRQ_STATUS: st_d.rdata = 8'(st_q.irq_st);
                IDX_IRQ_ENABLE: st_d.rdata = 8'(st_q.irq_en);
                IDX_IRQ_CLEAR: st_d.rdata = 8'h00;
                default:
                begin
                    st_d.rdata = 8'h00;
                    st_d.rresp = RESP_SLVERR;
                end
            endcase
        end
        st_d.arready = !st_d.rvalid;

        // Watchdog; >= also catches a period shortened mid-count
        wd_limit = st_q.swreg[F_WDPER_BIT] ? WD_SHORT_LIM : WD_LONG_LIM;
        if (!watchdog_enable || wd_kick)
            st_d.wd_cnt = '0;
        else if (st_q.wd_cnt >= wd_limit)
        begin
            st_d.wd_cnt = '0;
            st_d.wd_exp = 1'b1;
        end
        else
            st_d.wd_cnt = st_q.wd_cnt + 1'b1;

        // Overcurrent timer; switch recloses when the condition drops
        oc_active = oc_s && (st_q.swreg[F_OCTHR_LSB +: 2] != 2'h0)
            && (vbus_s || st_q.swreg[F_NOVBUS_BIT]);
        if (!oc_active)
        begin
            st_d.oc_cnt = '0;
            st_d.sw_open = 1'b0;
        end
        else if (st_q.oc_cnt < OC_LIM)
            st_d.oc_cnt = st_q.oc_cnt + 1'b1;
        else if (!st_q.swreg[F_INHIBIT_BIT])
            st_d.sw_open = 1'b1;

        // Sticky events; a set in the clearing cycle survives
        ev = '0;
        ev[IRQ_WD] = st_d.wd_exp;
        ev[IRQ_SWITCH] = st_d.sw_open && !st_q.sw_open;
        ev[IRQ_COOL] = cool_s && !st_q.prev_cool;
        ev[IRQ_WARM] = warm_s && !st_q.prev_warm;
        ev[IRQ_TREG] = die_s && !st_q.prev_die;
        st_d.prev_cool = cool_s;
        st_d.prev_warm = warm_s;
        st_d.prev_die = die_s;
        st_d.irq_st = (st_q.irq_st & ~clr) | ev;
        st_d.irq = |(st_d.irq_st & st_d.irq_en);

        // Selections to the analog blocks
        st_d.v_code = sat_code(st_q.breg[5:0]);
        st_d.vsys = st_q.breg[F_VSYS_LSB +: 2];
        st_d.oc_thr = st_q.swreg[F_OCTHR_LSB +: 2];
        st_d.set_pt = st_q.threg[F_SETPT_LSB +: 2];
        st_d.cold_sel = st_q.threg[F_COLD_BIT];
        st_d.hot_sel = st_q.threg[F_HOT_BIT];

        // Thermistor control of the charger
        st_d.stop = 1'b0;
        st_d.cur_red = 1'b0;
        st_d.volt_red = 1'b0;
        case (chf_thm_mode_t'(st_q.threg[F_MODE_LSB +: 2]))
            THM_IGNORE: ;
            THM_STOP: st_d.stop = hot_s || cold_s;
            THM_CUT_BOTH:
            begin
                st_d.cur_red = warm_s || cool_s;
                st_d.volt_red = warm_s || cool_s;
            end
            THM_CUT_CURRENT: st_d.cur_red = warm_s || cool_s;
            default: ;
        endcase
        st_d.fold = die_s;
        st_d.treg = die_s;
    end

    // Single state register, frozen while ce is low
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            st_q <= ST_RST;
        else if (ce)
            st_q <= st_d;
    end

    // Outputs come straight from the state register
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rdata = {24'h000000, st_q.rdata};
    assign s_axi_rresp = st_q.rresp;
    assign s_axi_rvalid = st_q.rvalid;
    assign battery_regulation_voltage_code = st_q.v_code;
    assign minimum_system_voltage_select = st_q.vsys;
    assign switch_overcurrent_threshold = st_q.oc_thr;
    assign junction_temperature_set_point = st_q.set_pt;
    assign cold_threshold_select = st_q.cold_sel;
    assign hot_threshold_select = st_q.hot_sel;
    assign battery_isolation_switch_open = st_q.sw_open;
    assign charge_stop = st_q.stop;
    assign charge_current_reduce = st_q.cur_red;
    assign regulation_voltage_reduce = st_q.volt_red;
    assign current_foldback = st_q.fold;
    assign thermal_regulation_status_flag = st_q.treg;
    assign watchdog_expired = st_q.wd_exp;
    assign irq = st_q.irq;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_commit;
        ce && st_q.aw_held && st_q.w_held && !st_q.bvalid;
    endsequence
    sequence s_wd_kick;
        s_commit ##0 (st_q.w_idx == IDX_SWITCH_WD && st_q.w_strb0 &&
            st_q.w_data[1:0] == WD_CLEAR_KEY && watchdog_enable);
    endsequence

    property p_code_sat;
        ce |=> battery_regulation_voltage_code ==
            (($past(st_q.breg[5:0]) > CODE_MAX) ?
            CODE_MAX : $past(st_q.breg[5:0]));
    endproperty
    a_code_sat: assert property (p_code_sat)
        else $error("regulation code not saturated");

    property p_vsys;
        ce |=> minimum_system_voltage_select == $past(st_q.breg[7:6]);
    endproperty
    a_vsys: assert property (p_vsys)
        else $error("minimum system select wrong");

    property p_wd_clear;
        s_wd_kick |=> st_q.wd_cnt == '0 && !watchdog_expired;
    endproperty
    a_wd_clear: assert property (p_wd_clear)
        else $error("watchdog not cleared");

    property p_wd_short;
        ce && watchdog_enable && st_q.swreg[F_WDPER_BIT] &&
            st_q.wd_cnt == WD_SHORT_LIM && !st_q.aw_held |=> watchdog_expired;
    endproperty
    a_wd_short: assert property (p_wd_short)
        else $error("short watchdog period missed");

    property p_open_cause;
        $rose(battery_isolation_switch_open) |->
            $past(!st_q.swreg[F_INHIBIT_BIT]) && $past(st_q.oc_cnt) == OC_LIM;
    endproperty
    a_open_cause: assert property (p_open_cause)
        else $error("switch opened without full debounce");

    property p_inhibit;
        ce && st_q.swreg[F_INHIBIT_BIT] && !st_q.sw_open |=> !st_q.sw_open;
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("switch opened while inhibited");

    property p_oc_off;
        ce && st_q.swreg[F_OCTHR_LSB +: 2] == 2'h0 |=>
            !st_q.sw_open && st_q.oc_cnt == '0;
    endproperty
    a_oc_off: assert property (p_oc_off)
        else $error("detection active with threshold off");

    property p_novbus;
        ce && !vbus_s && !st_q.swreg[F_NOVBUS_BIT] |=> st_q.oc_cnt == '0;
    endproperty
    a_novbus: assert property (p_novbus)
        else $error("protection active without input supply");

    property p_mode_ignore;
        ce && st_q.threg[1:0] == THM_IGNORE |=> !charge_stop &&
            !charge_current_reduce && !regulation_voltage_reduce;
    endproperty
    a_mode_ignore: assert property (p_mode_ignore)
        else $error("thermistor acted in ignore mode");

    property p_mode_stop;
        ce && st_q.threg[1:0] == THM_STOP && (hot_s || cold_s) |=> charge_stop;
    endproperty
    a_mode_stop: assert property (p_mode_stop)
        else $error("charging not stopped");

    property p_mode_cc;
        ce && st_q.threg[1:0] == THM_CUT_CURRENT |=>
            !regulation_voltage_reduce && !charge_stop;
    endproperty
    a_mode_cc: assert property (p_mode_cc)
        else $error("voltage cut in current-only mode");

    property p_treg;
        ce && die_s |=> current_foldback && thermal_regulation_status_flag;
    endproperty
    a_treg: assert property (p_treg)
        else $error("thermal regulation not flagged");
endmodule

//--- logic/chf_pkg.sv
// Constants for the charger switch, watchdog and thermistor config bank.
// Assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus.
package chf_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [5:0] IDX_BATT_REG = 6'h0f;
    localparam logic [5:0] IDX_SWITCH_WD = 6'h11;
    localparam logic [5:0] IDX_THERM = 6'h12;
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
    localparam logic [5:0] IDX_IRQ_ENABLE = 6'h21;
    localparam logic [5:0] IDX_IRQ_CLEAR = 6'h22;
    // Values after reset
    localparam logic [7:0] RST_BATT_REG = 8'h2b;
    localparam logic [7:0] RST_SWITCH_WD = 8'h30;
    localparam logic [7:0] RST_THERM = 8'h05;
    // Field positions
    localparam int F_VSYS_LSB = 6;
    localparam int F_WDCLR_LSB = 0;
    localparam int F_WDSW_BIT = 2;
    localparam int F_INHIBIT_BIT = 3;
    localparam int F_OCTHR_LSB = 4;
    localparam int F_WDPER_BIT = 6;
    localparam int F_NOVBUS_BIT = 7;
    localparam int F_MODE_LSB = 0;
    localparam int F_SETPT_LSB = 2;
    localparam int F_COLD_BIT = 4;
    localparam int F_HOT_BIT = 5;
    // Highest regulation code with its own voltage step
    localparam logic [5:0] CODE_MAX = 6'h37;
    localparam logic [1:0] WD_CLEAR_KEY = 2'h1;
    // Interrupt status bits
    localparam int IRQ_WD = 0;
    localparam int IRQ_SWITCH = 1;
    localparam int IRQ_COOL = 2;
    localparam int IRQ_WARM = 3;
    localparam int IRQ_TREG = 4;
    localparam int IRQ_W = 5;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Times and their cycle counts at the core clock rate
    localparam longint unsigned CLK_HZ = 64'd100000000;
    localparam longint unsigned WD_LONG_S = 64'd80;
    localparam longint unsigned WD_SHORT_S = 64'd32;
    localparam longint unsigned OC_DEB_MS = 64'd16;
    localparam longint unsigned WD_LONG_CYC = WD_LONG_S * CLK_HZ;
    localparam longint unsigned WD_SHORT_CYC = WD_SHORT_S * CLK_HZ;
    localparam longint unsigned OC_DEB_CYC = OC_DEB_MS * CLK_HZ / 64'd1000;
    localparam int WD_CNT_W = 33;
    localparam int OC_CNT_W = 21;
    // Thermistor control modes
    typedef enum logic [1:0] {
        THM_IGNORE,
        THM_STOP,
        THM_CUT_BOTH,
        THM_CUT_CURRENT
    } chf_thm_mode_t;
endpackage

//--- logic/chf_sync.sv
// Two-flop synchroniser for asynchronous level inputs.
// Assumes slow levels; a pulse shorter than a clock may be lost.
`timescale 1ns/1ps
module chf_sync
    import chf_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock, reset and freeze
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ce,
    // Levels in and out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } chf_sync_t;

    chf_sync_t st_q;
    chf_sync_t st_d;

    // First stage is read by the second stage only
    always_comb
    begin
        st_d.s1 = async_in;
        st_d.s2 = st_q.s1;
    end

    // Freeze with the block while ce is low
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            st_q <= '0;
        else if (ce)
            st_q <= st_d;
    end

    assign sync_out = st_q.s2;
endmodule

//--- tb/chf_config_bench.sv
// Self-checking bench for the charger switch and thermistor config bank.
// Assumes chf_pkg and chf_config are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
module chf_config_bench import chf_pkg::*;;
    localparam logic [7:0] A_BAT = {IDX_BATT_REG, 2'b00};
    localparam logic [7:0] A_SW = {IDX_SWITCH_WD, 2'b00};
    localparam logic [7:0] A_TH = {IDX_THERM, 2'b00};
    localparam logic [7:0] A_ST = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [7:0] A_EN = {IDX_IRQ_ENABLE, 2'b00};
    localparam logic [7:0] A_CL = {IDX_IRQ_CLEAR, 2'b00};
    // Bench drives and design answers
    logic core_clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, arready;
    logic [1:0] bresp, rresp, resp, code_lo, vsys, thr, setpt;
    logic bvalid, rvalid, coldsel, hotsel, sw_open, stop, cur, volt;
    logic oc = 1'b0, vbus = 1'b0, hot = 1'b0, warm = 1'b0, die = 1'b0;
    logic cool = 1'b0, cold = 1'b0;
    logic [3:0] strb = 4'h1;
    logic wde = 1'b0, fold, tflag, wd_exp, irq;
    logic [5:0] code;
    int err_count = 0, checks_done = 0, n;
    // Short counts so the watchdog and debounce fit in a quick run
    chf_config #(.WD_LONG_CYCLES(200), .WD_SHORT_CYCLES(100),
        .OC_DEB_CYCLES(20)) chf_config_i (.core_clk(core_clk), .rst(rst),
        .ce(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .batt_overcurrent(oc), .vbus_present(vbus),
        .temp_above_hot(hot), .temp_above_warm(warm),
        .temp_below_cool(cool), .temp_below_cold(cold),
        .die_above_set_point(die), .watchdog_enable(wde),
        .battery_regulation_voltage_code(code),
        .minimum_system_voltage_select(vsys),
        .switch_overcurrent_threshold(thr),
        .junction_temperature_set_point(setpt),
        .cold_threshold_select(coldsel), .hot_threshold_select(hotsel),
        .battery_isolation_switch_open(sw_open), .charge_stop(stop),
        .charge_current_reduce(cur), .regulation_voltage_reduce(volt),
        .current_foldback(fold), .thermal_regulation_status_flag(tflag),
        .watchdog_expired(wd_exp), .irq(irq));
    always #5 core_clk = ~core_clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (arready === 1'b1)
                arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task automatic t_reset;
        rd(A_BAT);
        chk(d, 32'h2b);
        rd(A_SW);
        chk(d, 32'h30);
        rd(A_TH);
        chk(d, 32'h05);
        chk({28'h0, thr, setpt}, 32'hd);
        rd(8'h50);
        chk({d[29:0], resp}, {30'h0, RESP_SLVERR});
        wr(8'h50, 8'hff);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("Test reset done");
    endtask
    // Codes above 55 clamp; reserved selections still read back
    task automatic t_code;
        logic [7:0] v [3] = '{8'hf8, 8'h6f, 8'hb7};
        foreach (v[i])
        begin
            wr(A_BAT, v[i]);
            repeat (2) @(posedge core_clk);
            chk({22'h0, resp, vsys, code}, {22'h0, RESP_OKAY, v[i][7:6],
                (v[i][5:0] > 6'd55) ? 6'd55 : v[i][5:0]});
            rd(A_BAT);
            chk(d, {24'h0, v[i]});
        end
        // A write with byte 0 not strobed leaves the register alone
        strb <= 4'h0;
        wr(A_BAT, 8'h00);
        strb <= 4'h1;
        rd(A_BAT);
        chk(d, 32'hb7);
        $display("Test code done");
    endtask
    task automatic t_therm;
        logic [2:0] e [4] = '{3'b000, 3'b100, 3'b011, 3'b010};
        // Hot side first, then the cold side
        for (int p = 0; p < 2; p++)
        begin
            hot <= (p == 0);
            warm <= (p == 0);
            cool <= (p == 1);
            cold <= (p == 1);
            for (int m = 0; m < 4; m++)
            begin
                wr(A_TH, 8'h3c | 8'(m));
                repeat (5) @(posedge core_clk);
                chk({29'h0, stop, cur, volt}, {29'h0, e[m]});
                chk({28'h0, hotsel, coldsel, setpt}, 32'hf);
            end
        end
        die <= 1'b1;
        repeat (5) @(posedge core_clk);
        chk({30'h0, fold, tflag}, 32'h3);
        rd(A_ST);
        chk({29'h0, d[4:2]}, 32'h7);
        hot <= 1'b0;
        warm <= 1'b0;
        cool <= 1'b0;
        cold <= 1'b0;
        die <= 1'b0;
        wr(A_CL, 8'h1f);
        $display("Test thermistor done");
    endtask
    // Each switch case ends with overcurrent held for well over 20 cycles
    task automatic sw_case(input logic [7:0] c, input logic vb, input
        logic exp);
        wr(A_SW, c);
        vbus <= vb;
        oc <= 1'b1;
        repeat (40) @(posedge core_clk);
        chk({29'h0, thr, sw_open}, {29'h0, c[5:4], exp});
    endtask
    task automatic t_oc;
        wr(A_EN, 8'h02);
        wr(A_SW, 8'h30);
        vbus <= 1'b1;
        oc <= 1'b1;
        for (n = 0; n < 60 && sw_open !== 1'b1; n++)
            @(posedge core_clk);
        chk(32'(n >= 20 && sw_open === 1'b1), 32'h1);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h1);
        oc <= 1'b0;
        wr(A_CL, 8'h02);
        repeat (3) @(posedge core_clk);
        chk({30'h0, irq, sw_open}, 32'h0);
        sw_case(8'h38, 1'b1, 1'b0);
        oc <= 1'b0;
        sw_case(8'h30, 1'b0, 1'b0);
        sw_case(8'hb0, 1'b0, 1'b1);
        sw_case(8'h80, 1'b0, 1'b0);
        oc <= 1'b0;
        $display("Test overcurrent done");
    endtask
    // Restart the count, optionally write a clear key, time the expiry
    task automatic wd_run(input logic [7:0] c, input logic [1:0] k,
        input int lo, input int hi);
        realtime t0;
        wde <= 1'b0;
        wr(A_SW, c);
        wde <= 1'b1;
        t0 = $realtime;
        if (k != 2'h0)
        begin
            repeat (70) @(posedge core_clk);
            wr(A_SW, c | {6'h0, k});
        end
        for (n = 0; n < 500 && wd_exp !== 1'b1; n++)
            @(posedge core_clk);
        n = int'(($realtime - t0) / 10.0);
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task automatic t_wd;
        wr(A_EN, 8'h01);
        wd_run(8'h30, 2'h0, 195, 206);
        wd_run(8'h70, 2'h0, 95, 106);
        wd_run(8'h74, 2'h0, 95, 106);
        wd_run(8'h70, 2'h1, 165, 185);
        wd_run(8'h70, 2'h2, 95, 106);
        wd_run(8'h70, 2'h3, 95, 106);
        wde <= 1'b0;
        chk({31'h0, irq}, 32'h1);
        wr(A_CL, 8'h01);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        $display("Test watchdog done");
    endtask
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main sequence after four reset cycles
    initial
    begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_code;
        t_therm;
        t_oc;
        t_wd;
        complete_run;
    end
    // Hang guard: a little over a thousand cycles are expected in all
    initial
    begin
        #200000;
        err_count++;
        complete_run;
    end
endmodule
